// ### src/arb_pkg.sv
// Operation
// - Mode pin high opens the host serial port
// - Radio always on; port, interrupt gated by pins
// - User bank is shared host and radio storage
// - Host reads and writes the status register
// - Host-exclusive bit lives in status, resets zero
// - Registers writable only from the host port
// - Passive mode: radio only, exclusive bit zero
// - Semi-passive mode serves radio and host requests
// - Exclusive clear: host NVM writes refused
// - Simultaneous requests: radio access goes first
// - Exclusive set: only host reaches memory, full
// - Exclusive set: radio memory requests get no response
// - Undefined host register read returns unspecified data
`default_nettype none

package arb_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int STAT_W = 8;

    // Status register layout
    localparam int EXCL_BIT   = 0;
    localparam int MODE_BIT   = 1;
    localparam int SUPPLY_BIT = 2;
    localparam int HOST_BIT   = 3;

    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h00;
    localparam logic [STAT_W-1:0] STATUS_RST  = 8'h00;
    localparam logic [DATA_W-1:0] UNDEF_DATA  = 16'h0000;

    // One access, from either requester
    typedef struct packed {
        logic              is_reg;
        logic              we;
        logic              nvm;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } acc_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RADIO,
        ST_HOST
    } arb_state_t;

endpackage

`default_nettype wire

// ### src/rf_host_memory_arbiter.sv
`default_nettype none

module rf_host_memory_arbiter (
    // Clocks and reset
    input  wire logic                    ref_clk_in,
    input  wire logic                    link_clk_in,
    input  wire logic                    sys_rst_in,
    // Pins
    input  wire logic                    mode_sel_in,
    input  wire logic                    supply_ok_in,
    input  wire logic                    host_present_in,
    // Radio side, ref_clk domain
    input  wire logic                    radio_req_in,
    input  wire arb_pkg::acc_req_t       radio_cmd_in,
    output logic                         radio_done_out,
    output logic                         radio_ignored_out,
    output logic [arb_pkg::DATA_W-1:0]   radio_rdata_out,
    // Host side, link_clk domain
    input  wire logic                    host_req_in,
    input  wire arb_pkg::acc_req_t       host_cmd_in,
    output logic                         host_ready_out,
    output logic                         host_done_out,
    output logic                         host_refused_out,
    output logic [arb_pkg::DATA_W-1:0]   host_rdata_out,
    // Memory port, ref_clk domain
    output logic                         mem_req_out,
    output arb_pkg::acc_req_t            mem_cmd_out,
    input  wire logic [arb_pkg::DATA_W-1:0] mem_rdata_in,
    input  wire logic                    mem_done_in,
    // Interrupt
    input  wire logic                    irq_event_in,
    output logic                         interrupt_out_n
);

    // Pin synchronisers, ref domain
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic       mode_s;
    logic       supply_s;
    logic       host_s;
    logic       port_en;
    logic       irq_en;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            pin_s1_r <= {host_present_in, supply_ok_in, mode_sel_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign mode_s   = pin_s2_r[0];
    assign supply_s = pin_s2_r[1];
    assign host_s   = pin_s2_r[2];
    assign port_en  = mode_s & supply_s;
    assign irq_en   = supply_s & host_s;

    // Link domain: host request capture
    logic              en_l1_r;
    logic              en_l2_r;
    logic              ack_l1_r;
    logic              ack_l2_r;
    logic              ack_l3_r;
    arb_pkg::acc_req_t hold_r;
    arb_pkg::acc_req_t hold_nxt;
    logic              req_tgl_r;
    logic              req_tgl_nxt;
    logic              busy_r;
    logic              busy_nxt;
    logic              hdone_r;
    logic              hdone_nxt;
    logic              href_r;
    logic              href_nxt;
    logic [arb_pkg::DATA_W-1:0] hrd_r;
    logic [arb_pkg::DATA_W-1:0] hrd_nxt;
    logic              ack_edge;

    // Ref side result, held stable until the next request
    logic              ack_tgl_r;
    logic              res_ref_r;
    logic [arb_pkg::DATA_W-1:0] res_rd_r;

    always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            en_l1_r  <= 1'b0;
            en_l2_r  <= 1'b0;
            ack_l1_r <= 1'b0;
            ack_l2_r <= 1'b0;
            ack_l3_r <= 1'b0;
        end else begin
            en_l1_r  <= port_en;
            en_l2_r  <= en_l1_r;
            ack_l1_r <= ack_tgl_r;
            ack_l2_r <= ack_l1_r;
            ack_l3_r <= ack_l2_r;
        end
    end

    assign ack_edge       = ack_l2_r ^ ack_l3_r;
    assign host_ready_out = en_l2_r & ~busy_r;

    always_comb begin
        hold_nxt    = hold_r;
        req_tgl_nxt = req_tgl_r;
        busy_nxt    = busy_r;
        hdone_nxt   = 1'b0;
        href_nxt    = href_r;
        hrd_nxt     = hrd_r;
        if (host_req_in && host_ready_out) begin
            hold_nxt    = host_cmd_in;
            req_tgl_nxt = ~req_tgl_r;
            busy_nxt    = 1'b1;
        end else if (busy_r && ack_edge) begin
            busy_nxt  = 1'b0;
            hdone_nxt = 1'b1;
            href_nxt  = res_ref_r;
            hrd_nxt   = res_rd_r;
        end
    end

    always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_r    <= '0;
            req_tgl_r <= 1'b0;
            busy_r    <= 1'b0;
            hdone_r   <= 1'b0;
            href_r    <= 1'b0;
            hrd_r     <= '0;
        end else begin
            hold_r    <= hold_nxt;
            req_tgl_r <= req_tgl_nxt;
            busy_r    <= busy_nxt;
            hdone_r   <= hdone_nxt;
            href_r    <= href_nxt;
            hrd_r     <= hrd_nxt;
        end
    end

    assign host_done_out    = hdone_r;
    assign host_refused_out = hdone_r & href_r;
    assign host_rdata_out   = hrd_r;

    // Ref domain: request toggle sync and arbiter
    logic              req_s1_r;
    logic              req_s2_r;
    logic              req_s3_r;
    logic              new_req;
    arb_pkg::arb_state_t state_r;
    arb_pkg::arb_state_t state_nxt;
    logic              pend_r;
    logic              pend_nxt;
    logic              excl_r;
    logic              excl_nxt;
    logic              mreq_r;
    logic              mreq_nxt;
    arb_pkg::acc_req_t mcmd_r;
    arb_pkg::acc_req_t mcmd_nxt;
    logic              rdone_r;
    logic              rdone_nxt;
    logic              rign_r;
    logic              rign_nxt;
    logic [arb_pkg::DATA_W-1:0] rrd_r;
    logic [arb_pkg::DATA_W-1:0] rrd_nxt;
    logic              ack_tgl_nxt;
    logic              res_ref_nxt;
    logic [arb_pkg::DATA_W-1:0] res_rd_nxt;
    logic              irq_n_r;
    logic              irq_n_nxt;
    logic              radio_valid;
    logic [arb_pkg::STAT_W-1:0] status_word;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    assign new_req     = req_s2_r ^ req_s3_r;
    assign radio_valid = radio_req_in & ~rdone_r & ~rign_r
                         & (state_r == arb_pkg::ST_IDLE);

    always_comb begin
        status_word = arb_pkg::STATUS_RST;
        status_word[arb_pkg::EXCL_BIT]   = excl_r;
        status_word[arb_pkg::MODE_BIT]   = mode_s;
        status_word[arb_pkg::SUPPLY_BIT] = supply_s;
        status_word[arb_pkg::HOST_BIT]   = host_s;
    end

    always_comb begin
        state_nxt   = state_r;
        pend_nxt    = pend_r;
        excl_nxt    = excl_r;
        mreq_nxt    = mreq_r;
        mcmd_nxt    = mcmd_r;
        rdone_nxt   = 1'b0;
        rign_nxt    = 1'b0;
        rrd_nxt     = rrd_r;
        ack_tgl_nxt = ack_tgl_r;
        res_ref_nxt = res_ref_r;
        res_rd_nxt  = res_rd_r;
        case (state_r)
            arb_pkg::ST_IDLE: begin
                if (radio_valid) begin
                    // Radio wins a tie; host stays pending
                    if (excl_r) begin
                        rign_nxt = 1'b1;
                    end else if (radio_cmd_in.is_reg) begin
                        rign_nxt = 1'b1;
                    end else begin
                        mreq_nxt  = 1'b1;
                        mcmd_nxt  = radio_cmd_in;
                        state_nxt = arb_pkg::ST_RADIO;
                    end
                end else if (pend_r) begin
                    pend_nxt = 1'b0;
                    if (hold_r.is_reg) begin
                        ack_tgl_nxt = ~ack_tgl_r;
                        res_ref_nxt = 1'b0;
                        if (hold_r.addr == arb_pkg::STATUS_ADDR) begin
                            res_rd_nxt = {{(arb_pkg::DATA_W -
                                            arb_pkg::STAT_W){1'b0}},
                                          status_word};
                            if (hold_r.we) begin
                                excl_nxt = hold_r.wdata[arb_pkg::EXCL_BIT]
                                           & mode_s;
                            end
                        end else begin
                            res_rd_nxt = arb_pkg::UNDEF_DATA;
                        end
                    end else if (hold_r.we && hold_r.nvm && !excl_r) begin
                        ack_tgl_nxt = ~ack_tgl_r;
                        res_ref_nxt = 1'b1;
                    end else begin
                        mreq_nxt  = 1'b1;
                        mcmd_nxt  = hold_r;
                        state_nxt = arb_pkg::ST_HOST;
                    end
                end
            end
            arb_pkg::ST_RADIO: begin
                if (mem_done_in) begin
                    mreq_nxt  = 1'b0;
                    rdone_nxt = 1'b1;
                    rrd_nxt   = mem_rdata_in;
                    state_nxt = arb_pkg::ST_IDLE;
                end
            end
            arb_pkg::ST_HOST: begin
                if (mem_done_in) begin
                    mreq_nxt    = 1'b0;
                    ack_tgl_nxt = ~ack_tgl_r;
                    res_ref_nxt = 1'b0;
                    res_rd_nxt  = mem_rdata_in;
                    state_nxt   = arb_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = arb_pkg::ST_IDLE;
            end
        endcase
        // Arrival beats the clear of the same cycle
        if (new_req) begin
            pend_nxt = 1'b1;
        end
        if (!mode_s) begin
            excl_nxt = 1'b0;
        end
        irq_n_nxt = ~(irq_event_in & irq_en);
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r   <= arb_pkg::ST_IDLE;
            pend_r    <= 1'b0;
            excl_r    <= arb_pkg::STATUS_RST[arb_pkg::EXCL_BIT];
            mreq_r    <= 1'b0;
            mcmd_r    <= '0;
            rdone_r   <= 1'b0;
            rign_r    <= 1'b0;
            rrd_r     <= '0;
            ack_tgl_r <= 1'b0;
            res_ref_r <= 1'b0;
            res_rd_r  <= '0;
            irq_n_r   <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            pend_r    <= pend_nxt;
            excl_r    <= excl_nxt;
            mreq_r    <= mreq_nxt;
            mcmd_r    <= mcmd_nxt;
            rdone_r   <= rdone_nxt;
            rign_r    <= rign_nxt;
            rrd_r     <= rrd_nxt;
            ack_tgl_r <= ack_tgl_nxt;
            res_ref_r <= res_ref_nxt;
            res_rd_r  <= res_rd_nxt;
            irq_n_r   <= irq_n_nxt;
        end
    end

    assign radio_done_out    = rdone_r;
    assign radio_ignored_out = rign_r;
    assign radio_rdata_out   = rrd_r;
    assign mem_req_out       = mreq_r;
    assign mem_cmd_out       = mcmd_r;
    assign interrupt_out_n   = irq_n_r;

    // Checks on the ref domain; port_gate_a runs on link_clk_in
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence radio_turn_s;
        radio_valid && !excl_r && !radio_cmd_in.is_reg;
    endsequence

    sequence host_nvm_write_s;
        !radio_valid && pend_r && (state_r == arb_pkg::ST_IDLE)
        && !hold_r.is_reg && hold_r.we && hold_r.nvm;
    endsequence

    passive_excl_a: assert property (!mode_s |=> !excl_r)
        else $error("exclusive bit set in passive mode");

    radio_first_a: assert property (radio_turn_s and pend_r
        |=> state_r == arb_pkg::ST_RADIO && pend_r && mem_req_out
            && mem_cmd_out == $past(radio_cmd_in))
        else $error("host served before radio");

    radio_mute_a: assert property (radio_valid && excl_r
        |=> radio_ignored_out && !mem_req_out ##1 !radio_done_out)
        else $error("radio answered while host exclusive");

    // Mode pin may drop in the same cycle and clear the bit
    radio_noreg_a: assert property (radio_valid && radio_cmd_in.is_reg
        |=> radio_ignored_out
            && excl_r == ($past(excl_r) && $past(mode_s)))
        else $error("radio register access not refused");

    nvm_refuse_a: assert property (host_nvm_write_s and !excl_r
        |=> !mem_req_out && res_ref_r && ack_tgl_r != $past(ack_tgl_r))
        else $error("host nvm write not refused");

    nvm_excl_a: assert property (host_nvm_write_s and excl_r
        |=> mem_req_out && state_r == arb_pkg::ST_HOST)
        else $error("exclusive host nvm write blocked");

    pend_keep_a: assert property (
        pend_r && state_r != arb_pkg::ST_IDLE |=> pend_r)
        else $error("pending host request dropped");

    // Gate may reopen a cycle later, so only the next cycle is bound
    irq_gate_a: assert property (!irq_en |=> interrupt_out_n)
        else $error("interrupt asserted while gated");

    status_wr_a: assert property (pend_r && !radio_valid
        && state_r == arb_pkg::ST_IDLE && hold_r.is_reg && hold_r.we
        && hold_r.addr == arb_pkg::STATUS_ADDR && mode_s && $stable(mode_s)
        |=> excl_r == $past(hold_r.wdata[arb_pkg::EXCL_BIT]))
        else $error("status write not taken");

    port_gate_a: assert property (@(posedge link_clk_in)
        disable iff (sys_rst_in) !en_l2_r |-> !host_ready_out)
        else $error("host port open in passive mode");

endmodule

`default_nettype wire

// ### sim/host_model.sv
`default_nettype none

module host_model (
    // Link side
    input  wire logic              link_clk_in,
    input  wire logic              host_ready_in,
    input  wire logic              host_done_in,
    input  wire logic              host_refused_in,
    input  wire logic [15:0]       host_rdata_in,
    // Requests
    output logic                   host_req_out,
    output arb_pkg::acc_req_t      host_cmd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        host_req_out = 1'b0;
        host_cmd_out = '0;
    end

    // One outstanding access; ok low if the port never answered
    task automatic xfer(input arb_pkg::acc_req_t c,
                        output logic [15:0] d,
                        output logic refd,
                        output logic ok);
        int n;
        n = 0;
        @(negedge link_clk_in);
        host_req_out = 1'b1;
        host_cmd_out = c;
        while (host_ready_in !== 1'b1 && n < 400) begin
            @(negedge link_clk_in);
            n++;
        end
        @(negedge link_clk_in);
        host_req_out = 1'b0;
        // Released lines carry garbage, never the old command
        host_cmd_out = ~c;
        while (host_done_in !== 1'b1 && n < 800) begin
            @(negedge link_clk_in);
            n++;
        end
        ok = (n < 800);
        d = host_rdata_in;
        refd = host_refused_in;
    endtask

endmodule

`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk_in = 1'b0;
    logic              link_clk_in = 1'b0;
    logic              sys_rst_in = 1'b1;
    logic              mode_sel_in = 1'b0;
    logic              supply_ok_in = 1'b1;
    logic              host_present_in = 1'b1;
    logic              radio_req_in = 1'b0;
    arb_pkg::acc_req_t radio_cmd_in = '0;
    logic              radio_done_out;
    logic              radio_ignored_out;
    logic [15:0]       radio_rdata_out;
    logic              host_req_in;
    arb_pkg::acc_req_t host_cmd_in;
    logic              host_ready_out;
    logic              host_done_out;
    logic              host_refused_out;
    logic [15:0]       host_rdata_out;
    logic              mem_req_out;
    arb_pkg::acc_req_t mem_cmd_out;
    logic [15:0]       mem_rdata_in = 16'h0000;
    logic              mem_done_in = 1'b0;
    logic              irq_event_in = 1'b0;
    logic              interrupt_out_n;
    logic [15:0]       mem [256];
    logic [1:0]        wt = 2'h0;
    int                bad_count = 0;
    int                num_checks = 0;

    always #25 ref_clk_in = ~ref_clk_in;
    always #7.5 link_clk_in = ~link_clk_in;

    rf_host_memory_arbiter i_dut (
        .ref_clk_in(ref_clk_in), .link_clk_in(link_clk_in),
        .sys_rst_in(sys_rst_in), .mode_sel_in(mode_sel_in),
        .supply_ok_in(supply_ok_in), .host_present_in(host_present_in),
        .radio_req_in(radio_req_in), .radio_cmd_in(radio_cmd_in),
        .radio_done_out(radio_done_out),
        .radio_ignored_out(radio_ignored_out),
        .radio_rdata_out(radio_rdata_out),
        .host_req_in(host_req_in), .host_cmd_in(host_cmd_in),
        .host_ready_out(host_ready_out), .host_done_out(host_done_out),
        .host_refused_out(host_refused_out),
        .host_rdata_out(host_rdata_out), .mem_req_out(mem_req_out),
        .mem_cmd_out(mem_cmd_out), .mem_rdata_in(mem_rdata_in),
        .mem_done_in(mem_done_in), .irq_event_in(irq_event_in),
        .interrupt_out_n(interrupt_out_n));

    host_model i_host (
        .link_clk_in(link_clk_in), .host_ready_in(host_ready_out),
        .host_done_in(host_done_out), .host_refused_in(host_refused_out),
        .host_rdata_in(host_rdata_out), .host_req_out(host_req_in),
        .host_cmd_out(host_cmd_in));

    initial for (int i = 0; i < 256; i++) mem[i] = 16'(i);

    // Slow memory; idle data line toggles so stale data cannot match
    always @(negedge ref_clk_in) begin
        mem_done_in <= 1'b0;
        mem_rdata_in <= ~mem_rdata_in;
        if (mem_req_out === 1'b1 && mem_done_in !== 1'b1) begin
            if (wt == 2'h2) begin
                wt <= 2'h0;
                mem_done_in <= 1'b1;
                if (mem_cmd_out.we)
                    mem[mem_cmd_out.addr] <= mem_cmd_out.wdata;
                else
                    mem_rdata_in <= mem[mem_cmd_out.addr];
            end else wt <= wt + 2'h1;
        end
    end

    function automatic arb_pkg::acc_req_t mk(logic r, logic w, logic n,
                                             logic [7:0] a,
                                             logic [15:0] d);
        return '{r, w, n, a, d};
    endfunction

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic radio(input arb_pkg::acc_req_t c,
                         output logic [15:0] d, output logic ign);
        int n;
        n = 0;
        radio_req_in = 1'b1;
        radio_cmd_in = c;
        do begin
            @(negedge ref_clk_in);
            n++;
        end while (radio_done_out !== 1'b1 && radio_ignored_out !== 1'b1
                   && n < 100);
        chk("radio answer", 16'h0001, 16'(n < 100));
        d = radio_rdata_out;
        ign = radio_ignored_out;
        radio_req_in = 1'b0;
        radio_cmd_in = ~c;
        @(negedge ref_clk_in);
    endtask

    task automatic host(input arb_pkg::acc_req_t c,
                        output logic [15:0] d, output logic refd);
        logic ok;
        i_host.xfer(c, d, refd, ok);
        chk("host answer", 16'h0001, 16'(ok));
        @(negedge ref_clk_in);
    endtask

    task automatic settle();
        repeat (10) @(negedge ref_clk_in);
    endtask

    task automatic t_passive();
        logic [15:0] d;
        logic        g;
        settle();
        chk("ready passive", 16'h0000, 16'(host_ready_out));
        radio(mk(1'b0, 1'b1, 1'b1, 8'h0a, 16'h1234), d, g);
        radio(mk(1'b0, 1'b0, 1'b1, 8'h0a, 16'h0000), d, g);
        chk("radio nvm rd", 16'h1234, d);
        chk("radio nvm ign", 16'h0000, 16'(g));
        radio(mk(1'b1, 1'b1, 1'b0, 8'h00, 16'h0001), d, g);
        chk("radio reg ign", 16'h0001, 16'(g));
        $display("test passive done");
    endtask

    task automatic t_shared();
        logic [15:0] d;
        logic        g;
        mode_sel_in = 1'b1;
        settle();
        chk("ready semi", 16'h0001, 16'(host_ready_out));
        host(mk(1'b1, 1'b0, 1'b0, 8'h00, 16'h0000), d, g);
        chk("status", 16'h000e, d);
        host(mk(1'b0, 1'b1, 1'b0, 8'h14, 16'h5a5a), d, g);
        chk("ram wr ref", 16'h0000, 16'(g));
        radio(mk(1'b0, 1'b0, 1'b0, 8'h14, 16'h0000), d, g);
        chk("shared ram", 16'h5a5a, d);
        host(mk(1'b0, 1'b1, 1'b1, 8'h1e, 16'hbeef), d, g);
        chk("nvm wr ref", 16'h0001, 16'(g));
        radio(mk(1'b0, 1'b0, 1'b1, 8'h1e, 16'h0000), d, g);
        chk("nvm kept", 16'h001e, d);
        $display("test shared done");
    endtask

    task automatic t_excl();
        logic [15:0] d;
        logic        g;
        host(mk(1'b1, 1'b1, 1'b0, 8'h00, 16'h0001), d, g);
        host(mk(1'b1, 1'b0, 1'b0, 8'h00, 16'h0000), d, g);
        chk("status excl", 16'h000f, d);
        radio(mk(1'b0, 1'b0, 1'b0, 8'h14, 16'h0000), d, g);
        chk("radio blocked", 16'h0001, 16'(g));
        radio(mk(1'b0, 1'b1, 1'b1, 8'h1e, 16'h7777), d, g);
        chk("radio wr blk", 16'h0001, 16'(g));
        host(mk(1'b0, 1'b1, 1'b1, 8'h1e, 16'hbeef), d, g);
        chk("excl nvm ref", 16'h0000, 16'(g));
        host(mk(1'b0, 1'b0, 1'b1, 8'h1e, 16'h0000), d, g);
        chk("excl nvm rd", 16'hbeef, d);
        mode_sel_in = 1'b0;
        settle();
        mode_sel_in = 1'b1;
        settle();
        host(mk(1'b1, 1'b0, 1'b0, 8'h00, 16'h0000), d, g);
        chk("excl cleared", 16'h000e, d);
        $display("test excl done");
    endtask

    task automatic t_tie();
        logic [15:0] d;
        logic [15:0] e;
        logic        g;
        logic        h;
        fork
            host(mk(1'b0, 1'b1, 1'b0, 8'h28, 16'h1111), d, g);
            radio(mk(1'b0, 1'b1, 1'b0, 8'h28, 16'h2222), e, h);
        join
        chk("tie refused", 16'h0000, 16'(g));
        radio(mk(1'b0, 1'b0, 1'b0, 8'h28, 16'h0000), e, h);
        chk("host last", 16'h1111, e);
        $display("test tie done");
    endtask

    task automatic t_irq();
        irq_event_in = 1'b1;
        settle();
        chk("irq on", 16'h0000, 16'(interrupt_out_n));
        supply_ok_in = 1'b0;
        settle();
        chk("irq gated", 16'h0001, 16'(interrupt_out_n));
        chk("port gated", 16'h0000, 16'(host_ready_out));
        irq_event_in = 1'b0;
        supply_ok_in = 1'b1;
        $display("test irq done");
    endtask

    task automatic conclude();
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Tests need well under 100 us
    initial begin
        #400000;
        bad_count++;
        conclude();
    end

    initial begin
        repeat (3) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        t_passive();
        t_shared();
        t_excl();
        t_tie();
        t_irq();
        conclude();
    end

endmodule

`default_nettype wire
